// ==== src/ssave_pkg.sv ====
// package: save area layout, register map and section table for the save unit
// How it works
// - control/status word kept at legacy bytes 27:24
// - restore faults on reserved control/status bits
// - restore ignores the mask word at 31:28
// - vec128 regs 0-7 at bytes 287:160
// - vec128 regs 8-15 only in 64-bit mode
// - vec128 state needs save-enable and mask bit 1
// - upper 256-bit halves form component 2
// - component 2 halves 8-15 only in 64-bit mode
// - component 2 and 256-bit ops need mask bit 2
// - query leaf 0DH reports section offset and size
// - component 3 holds four 16-byte bounds registers
// - component 4 holds bounds config then status
// - bounds state needs mask bits 4:3 set
// - 512-bit state split into components 5 to 7
// - component 5 holds eight 8-byte mask registers
// - component 6 halves 8-15 only in 64-bit mode
// - component 7 only in 64-bit mode
// - components 5-7 need mask bits 7:5 set
// - feature mask bit 0 always reads one
// - extended region starts at byte 576
// - compacted aligned sections start on 64-byte boundary
package ssave_pkg;
  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [7:0]  REG_FEATURE   = 8'h00;
  localparam logic [7:0]  REG_CONTROL   = 8'h04;
  localparam logic [7:0]  REG_BASE      = 8'h08;
  localparam logic [7:0]  REG_COMMAND   = 8'h0C;
  localparam logic [7:0]  REG_STATUS    = 8'h10;
  localparam logic [7:0]  REG_QUERY_SEL = 8'h14;
  localparam logic [7:0]  REG_QUERY_OFF = 8'h18;
  localparam logic [7:0]  REG_QUERY_SZ  = 8'h1C;
  localparam logic [7:0]  FEATURE_RST   = 8'h01;
  localparam logic [7:0]  QUERY_LEAF    = 8'h0D;
  localparam logic [31:0] CSR_VALID     = 32'h0000FFFF;
  localparam logic [31:0] CSR_MASK_VAL  = 32'h0000FFFF;
  // --------------------------------------------------------------
  // save area layout
  // --------------------------------------------------------------
  localparam logic [15:0] CSR_OFF       = 16'h0018;
  localparam logic [15:0] V128_LO_OFF   = 16'h00A0;
  localparam logic [15:0] V128_HI_OFF   = 16'h0120;
  localparam logic [15:0] V256_HI_OFF   = 16'h0080;
  localparam logic [15:0] V512H_HI_OFF  = 16'h0100;
  localparam logic [15:0] EXT_BASE      = 16'h0240;
  localparam logic [15:0] LINE_MASK     = 16'h003F;
  localparam logic [15:0] SIZE_C2       = 16'h0100;
  localparam logic [15:0] SIZE_C3       = 16'h0040;
  localparam logic [15:0] SIZE_C4       = 16'h0010;
  localparam logic [15:0] SIZE_C5       = 16'h0040;
  localparam logic [15:0] SIZE_C6       = 16'h0200;
  localparam logic [15:0] SIZE_C7       = 16'h0400;
  localparam logic [3:0]  SEG_CSR       = 4'h0;
  localparam logic [3:0]  SEG_COUNT     = 4'hB;

  typedef struct packed {
    logic [2:0]  comp;
    logic [15:0] off;
    logic [7:0]  words;
    logic        need64;
  } seg_s;

  function automatic logic [15:0] comp_size(input logic [2:0] c);
    unique case (c)
      3'h2:    comp_size = SIZE_C2;
      3'h3:    comp_size = SIZE_C3;
      3'h4:    comp_size = SIZE_C4;
      3'h5:    comp_size = SIZE_C5;
      3'h6:    comp_size = SIZE_C6;
      3'h7:    comp_size = SIZE_C7;
      default: comp_size = 16'h0000;
    endcase
  endfunction : comp_size

  // walk order: control word first, so a bad restore faults before any write
  function automatic seg_s seg_info(input logic [3:0] s);
    unique case (s)
      4'h0:    seg_info = '{3'h1, CSR_OFF, 8'h01, 1'b0};
      4'h1:    seg_info = '{3'h1, V128_LO_OFF, 8'h10, 1'b0};
      4'h2:    seg_info = '{3'h1, V128_HI_OFF, 8'h10, 1'b1};
      4'h3:    seg_info = '{3'h2, 16'h0000, 8'h10, 1'b0};
      4'h4:    seg_info = '{3'h2, V256_HI_OFF, 8'h10, 1'b1};
      4'h5:    seg_info = '{3'h3, 16'h0000, 8'h08, 1'b0};
      4'h6:    seg_info = '{3'h4, 16'h0000, 8'h02, 1'b0};
      4'h7:    seg_info = '{3'h5, 16'h0000, 8'h08, 1'b0};
      4'h8:    seg_info = '{3'h6, 16'h0000, 8'h20, 1'b0};
      4'h9:    seg_info = '{3'h6, V512H_HI_OFF, 8'h20, 1'b1};
      4'hA:    seg_info = '{3'h7, 16'h0000, 8'h80, 1'b1};
      default: seg_info = '{3'h0, 16'h0000, 8'h01, 1'b0};
    endcase
  endfunction : seg_info
endpackage : ssave_pkg

// ==== src/layout_if.sv ====
// interface: feature gating and section placement between unit parts
`timescale 1ns/100ps
`default_nettype none
interface layout_if;
  logic [7:0]  feat;
  logic        os_en;
  logic [7:0]  comp_en;
  logic        compact;
  logic [7:0]  present;
  logic [15:0] loc     [8];
  logic [15:0] std_loc [8];
  modport gate    (input feat, os_en, output comp_en);
  modport locator (input compact, present, output loc, std_loc);
  modport user    (output feat, os_en, compact, present,
                   input comp_en, loc, std_loc);
endinterface : layout_if
`default_nettype wire

// ==== src/feature_gate.sv ====
// module: which state components the save unit may touch
`timescale 1ns/100ps
`default_nettype none
module feature_gate (
  layout_if.gate lay
);
  // each group needs save-enable and all of its mask bits
  always_comb begin
    lay.comp_en    = 8'h00;
    lay.comp_en[1] = lay.os_en & lay.feat[1];
    lay.comp_en[2] = lay.os_en & lay.feat[2];
    lay.comp_en[3] = lay.os_en & (&lay.feat[4:3]);
    lay.comp_en[4] = lay.os_en & (&lay.feat[4:3]);
    lay.comp_en[5] = lay.os_en & (&lay.feat[7:5]);
    lay.comp_en[6] = lay.os_en & (&lay.feat[7:5]);
    lay.comp_en[7] = lay.os_en & (&lay.feat[7:5]);
  end
endmodule : feature_gate
`default_nettype wire

// ==== src/region_locator.sv ====
// module: standard and compacted placement of extended sections
`timescale 1ns/100ps
`default_nettype none
module region_locator #(
  parameter logic [7:0] ALIGN_MASK = 8'h00
) (
  layout_if.locator lay
);
  // standard layout packs sections from 576; compacted skips absent ones
  always_comb begin
    logic [15:0] run_s;
    logic [15:0] run_c;
    run_s = ssave_pkg::EXT_BASE;
    run_c = ssave_pkg::EXT_BASE;
    for (int i = 0; i < 8; i++) begin
      lay.loc[i]     = 16'h0000;
      lay.std_loc[i] = 16'h0000;
    end
    for (int i = 2; i < 8; i++) begin
      lay.std_loc[i] = run_s;
      run_s = run_s + ssave_pkg::comp_size(3'(i));
      if (lay.present[i]) begin
        if (ALIGN_MASK[i]) begin
          run_c = (run_c + ssave_pkg::LINE_MASK) & ~ssave_pkg::LINE_MASK;
        end
        lay.loc[i] = lay.compact ? run_c : lay.std_loc[i];
        run_c = run_c + ssave_pkg::comp_size(3'(i));
      end
    end
  end
endmodule : region_locator
`default_nettype wire

// ==== src/state_save_unit.sv ====
// module: vector, bounds and mask state save and restore engine
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module state_save_unit #(
  parameter logic [7:0] ALIGN_MASK = 8'h00
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  output var  logic        mem_rd,
  output var  logic        mem_wr,
  output var  logic [31:0] mem_addr,
  output var  logic [63:0] mem_wdata,
  output var  logic [7:0]  mem_be,
  input  wire logic [63:0] mem_rdata,
  output var  logic        sf_rd,
  output var  logic        sf_wr,
  output var  logic [2:0]  sf_comp,
  output var  logic [7:0]  sf_idx,
  output var  logic [63:0] sf_wdata,
  input  wire logic [63:0] sf_rdata,
  output var  logic        gp_fault,
  output var  logic        op_done,
  output var  logic        allow_vec256,
  output var  logic        allow_bounds,
  output var  logic        allow_vec512
);
  typedef enum logic [2:0] {S_IDLE, S_SCAN, S_ISSUE, S_WAIT, S_XFER} fsm_e;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]  feature_r,  feature_nxt;
  logic [1:0]  ctrl_r,     ctrl_nxt;
  logic [31:0] base_r,     base_nxt;
  logic        restore_r,  restore_nxt;
  logic        compact_r,  compact_nxt;
  logic        mode64_r,   mode64_nxt;
  logic [7:0]  rfbm_r,     rfbm_nxt;
  logic [2:0]  sticky_r,   sticky_nxt;
  logic [15:0] qsel_r,     qsel_nxt;
  logic [31:0] rdata_r,    rdata_nxt;
  logic [2:0]  allow_r,    allow_nxt;

  // ----------------------------------------------------------------
  // engine state
  // ----------------------------------------------------------------
  fsm_e        st_r,       st_nxt;
  logic [3:0]  seg_r,      seg_nxt;
  logic [7:0]  cnt_r,      cnt_nxt;
  logic        mem_rd_r,   mem_rd_nxt;
  logic        mem_wr_r,   mem_wr_nxt;
  logic [31:0] mem_addr_r, mem_addr_nxt;
  logic [63:0] mem_wd_r,   mem_wd_nxt;
  logic        sf_rd_r,    sf_rd_nxt;
  logic        sf_wr_r,    sf_wr_nxt;
  logic [2:0]  sf_comp_r,  sf_comp_nxt;
  logic [7:0]  sf_idx_r,   sf_idx_nxt;
  logic [63:0] sf_wd_r,    sf_wd_nxt;
  logic        fault_r,    fault_nxt;
  logic        done_r,     done_nxt;

  logic              start;
  logic              refuse;
  logic              seg_live;
  logic              csr_bad;
  ssave_pkg::seg_s   seg;
  logic [15:0]       sec_base;
  logic [31:0]       word_addr;
  logic [15:0]       q_off;
  logic [15:0]       q_size;
  logic              q_hit;

  layout_if lay ();

  feature_gate u_gate (
    .lay (lay.gate)
  );

  region_locator #(
    .ALIGN_MASK (ALIGN_MASK)
  ) u_loc (
    .lay (lay.locator)
  );

  // ----------------------------------------------------------------
  // component selection and word addressing
  // ----------------------------------------------------------------
  // gating inputs, current section and its memory address
  assign lay.feat    = feature_r;
  assign lay.os_en   = ctrl_r[0];
  assign lay.compact = compact_r;
  assign lay.present = lay.comp_en & rfbm_r;
  assign seg         = ssave_pkg::seg_info(seg_r);
  assign seg_live    = lay.present[seg.comp] & (~seg.need64 | mode64_r);
  assign sec_base    = (seg.comp == 3'h1) ? 16'h0000 : lay.loc[seg.comp];
  assign word_addr   = base_r + {16'h0000, sec_base} + {16'h0000, seg.off}
                     + {21'h000000, cnt_r, 3'h0};
  assign csr_bad     = |(mem_rdata[31:0] & ~ssave_pkg::CSR_VALID);
  assign start       = reg_wr & (reg_addr == ssave_pkg::REG_COMMAND) & (st_r == S_IDLE);
  assign refuse      = start & ~ctrl_r[0];

  // query answers only for leaf 0DH and extended subleaves
  assign q_hit  = (qsel_r[7:0] == ssave_pkg::QUERY_LEAF)
                & (qsel_r[15:8] >= 8'h02) & (qsel_r[15:8] <= 8'h07);
  assign q_off  = q_hit ? lay.std_loc[qsel_r[10:8]] : 16'h0000;
  assign q_size = q_hit ? ssave_pkg::comp_size(qsel_r[10:8]) : 16'h0000;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // writes, command latch, sticky status and read mux
  always_comb begin
    feature_nxt = feature_r;
    ctrl_nxt    = ctrl_r;
    base_nxt    = base_r;
    restore_nxt = restore_r;
    compact_nxt = compact_r;
    mode64_nxt  = mode64_r;
    rfbm_nxt    = rfbm_r;
    sticky_nxt  = sticky_r;
    qsel_nxt    = qsel_r;
    rdata_nxt   = 32'h00000000;
    allow_nxt   = {lay.comp_en[5], lay.comp_en[3], lay.comp_en[2]};
    if (reg_wr) begin
      unique case (reg_addr)
        ssave_pkg::REG_FEATURE:   feature_nxt = {reg_wdata[7:1], 1'b1};
        ssave_pkg::REG_CONTROL:   ctrl_nxt    = reg_wdata[1:0];
        ssave_pkg::REG_BASE:      base_nxt    = {reg_wdata[31:3], 3'h0};
        ssave_pkg::REG_STATUS:    sticky_nxt  = sticky_r & ~reg_wdata[3:1];
        ssave_pkg::REG_QUERY_SEL: qsel_nxt    = reg_wdata[15:0];
        default: ;
      endcase
    end
    if (start & ctrl_r[0]) begin
      restore_nxt = reg_wdata[0];
      compact_nxt = reg_wdata[1];
      rfbm_nxt    = reg_wdata[15:8];
      mode64_nxt  = ctrl_r[1];
    end
    // a new event wins over a clear in the same cycle
    if (fault_nxt) sticky_nxt[0] = 1'b1;
    if (refuse)    sticky_nxt[1] = 1'b1;
    if (done_nxt)  sticky_nxt[2] = 1'b1;
    if (reg_rd) begin
      unique case (reg_addr)
        ssave_pkg::REG_FEATURE:   rdata_nxt = {24'h000000, feature_r};
        ssave_pkg::REG_CONTROL:   rdata_nxt = {30'h00000000, ctrl_r};
        ssave_pkg::REG_BASE:      rdata_nxt = base_r;
        ssave_pkg::REG_COMMAND:   rdata_nxt = {16'h0000, rfbm_r, 6'h00, compact_r, restore_r};
        ssave_pkg::REG_STATUS:    rdata_nxt = {25'h0000000, allow_r, sticky_r,
                                               (st_r != S_IDLE)};
        ssave_pkg::REG_QUERY_SEL: rdata_nxt = {16'h0000, qsel_r};
        ssave_pkg::REG_QUERY_OFF: rdata_nxt = {16'h0000, q_off};
        ssave_pkg::REG_QUERY_SZ:  rdata_nxt = {16'h0000, q_size};
        default:                  rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      feature_r <= ssave_pkg::FEATURE_RST;
      ctrl_r    <= 2'h0;
      base_r    <= 32'h00000000;
      restore_r <= 1'b0;
      compact_r <= 1'b0;
      mode64_r  <= 1'b0;
      rfbm_r    <= 8'h00;
      sticky_r  <= 3'h0;
      qsel_r    <= 16'h0000;
      rdata_r   <= 32'h00000000;
      allow_r   <= 3'h0;
    end else begin
      feature_r <= feature_nxt;
      ctrl_r    <= ctrl_nxt;
      base_r    <= base_nxt;
      restore_r <= restore_nxt;
      compact_r <= compact_nxt;
      mode64_r  <= mode64_nxt;
      rfbm_r    <= rfbm_nxt;
      sticky_r  <= sticky_nxt;
      qsel_r    <= qsel_nxt;
      rdata_r   <= rdata_nxt;
      allow_r   <= allow_nxt;
    end
  end

  // ----------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------
  // one 64-bit word per three cycles: issue, wait for data, move it
  always_comb begin
    st_nxt       = st_r;
    seg_nxt      = seg_r;
    cnt_nxt      = cnt_r;
    mem_rd_nxt   = 1'b0;
    mem_wr_nxt   = 1'b0;
    mem_addr_nxt = mem_addr_r;
    mem_wd_nxt   = mem_wd_r;
    sf_rd_nxt    = 1'b0;
    sf_wr_nxt    = 1'b0;
    sf_comp_nxt  = sf_comp_r;
    sf_idx_nxt   = sf_idx_r;
    sf_wd_nxt    = sf_wd_r;
    fault_nxt    = 1'b0;
    done_nxt     = 1'b0;
    unique case (st_r)
      S_IDLE: begin
        if (start & ctrl_r[0]) begin
          seg_nxt = 4'h0;
          cnt_nxt = 8'h00;
          st_nxt  = S_SCAN;
        end
      end
      S_SCAN: begin
        if (seg_r == ssave_pkg::SEG_COUNT) begin
          done_nxt = 1'b1;
          st_nxt   = S_IDLE;
        end else if (seg_live) begin
          cnt_nxt = 8'h00;
          st_nxt  = S_ISSUE;
        end else begin
          seg_nxt = seg_r + 4'h1;
        end
      end
      S_ISSUE: begin
        sf_comp_nxt  = seg.comp;
        sf_idx_nxt   = seg.off[10:3] + cnt_r;
        mem_addr_nxt = word_addr;
        mem_rd_nxt   = restore_r;
        sf_rd_nxt    = ~restore_r;
        st_nxt       = S_WAIT;
      end
      S_WAIT: begin
        st_nxt = S_XFER;
      end
      S_XFER: begin
        if (!restore_r) begin
          mem_wr_nxt = 1'b1;
          mem_wd_nxt = (seg_r == ssave_pkg::SEG_CSR)
                     ? {ssave_pkg::CSR_MASK_VAL, sf_rdata[31:0]} : sf_rdata;
        end else if ((seg_r == ssave_pkg::SEG_CSR) && csr_bad) begin
          fault_nxt = 1'b1;
        end else begin
          sf_wr_nxt = 1'b1;
          sf_wd_nxt = (seg_r == ssave_pkg::SEG_CSR)
                    ? {32'h00000000, mem_rdata[31:0]} : mem_rdata;
        end
        if (fault_nxt) begin
          st_nxt = S_IDLE;
        end else if (cnt_r == seg.words - 8'h01) begin
          seg_nxt = seg_r + 4'h1;
          st_nxt  = S_SCAN;
        end else begin
          cnt_nxt = cnt_r + 8'h01;
          st_nxt  = S_ISSUE;
        end
      end
    endcase
  end

  // engine flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r       <= S_IDLE;
      seg_r      <= 4'h0;
      cnt_r      <= 8'h00;
      mem_rd_r   <= 1'b0;
      mem_wr_r   <= 1'b0;
      mem_addr_r <= 32'h00000000;
      mem_wd_r   <= 64'h0000000000000000;
      sf_rd_r    <= 1'b0;
      sf_wr_r    <= 1'b0;
      sf_comp_r  <= 3'h0;
      sf_idx_r   <= 8'h00;
      sf_wd_r    <= 64'h0000000000000000;
      fault_r    <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      seg_r      <= seg_nxt;
      cnt_r      <= cnt_nxt;
      mem_rd_r   <= mem_rd_nxt;
      mem_wr_r   <= mem_wr_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_wd_r   <= mem_wd_nxt;
      sf_rd_r    <= sf_rd_nxt;
      sf_wr_r    <= sf_wr_nxt;
      sf_comp_r  <= sf_comp_nxt;
      sf_idx_r   <= sf_idx_nxt;
      sf_wd_r    <= sf_wd_nxt;
      fault_r    <= fault_nxt;
      done_r     <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a flop
  assign reg_rdata    = rdata_r;
  assign mem_rd       = mem_rd_r;
  assign mem_wr       = mem_wr_r;
  assign mem_addr     = mem_addr_r;
  assign mem_wdata    = mem_wd_r;
  assign mem_be       = {8{mem_wr_r}};
  assign sf_rd        = sf_rd_r;
  assign sf_wr        = sf_wr_r;
  assign sf_comp      = sf_comp_r;
  assign sf_idx       = sf_idx_r;
  assign sf_wdata     = sf_wd_r;
  assign gp_fault     = fault_r;
  assign op_done      = done_r;
  assign allow_vec256 = allow_r[0];
  assign allow_bounds = allow_r[1];
  assign allow_vec512 = allow_r[2];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_feat_bit0;
    feature_r[0];
  endproperty
  a_feat_bit0: assert property (p_feat_bit0) else $error("mask bit 0 cleared");

  property p_csr_save_addr;
    (sf_rd_r && sf_comp_r == 3'h1 && sf_idx_r == 8'h03)
      |-> ##2 (mem_wr_r && mem_addr_r == base_r + 32'h00000018
               && mem_wdata[63:32] == ssave_pkg::CSR_MASK_VAL);
  endproperty
  a_csr_save_addr: assert property (p_csr_save_addr) else $error("csr save misplaced");

  property p_csr_fault;
    (mem_rd_r && sf_comp_r == 3'h1 && sf_idx_r == 8'h03) ##1 csr_bad
      |=> gp_fault ##1 (!sf_wr_r && st_r == S_IDLE);
  endproperty
  a_csr_fault: assert property (p_csr_fault) else $error("no fault on bad csr");

  property p_mask_ignored;
    (sf_wr_r && sf_comp_r == 3'h1 && sf_idx_r == 8'h03) |-> sf_wdata[63:32] == 32'h00000000;
  endproperty
  a_mask_ignored: assert property (p_mask_ignored) else $error("mask word loaded");

  property p_vec0_addr;
    (sf_rd_r && sf_comp_r == 3'h1 && sf_idx_r == 8'h14)
      |-> ##2 (mem_wr_r && mem_addr_r == base_r + 32'h000000A0);
  endproperty
  a_vec0_addr: assert property (p_vec0_addr) else $error("vec128 reg 0 misplaced");

  property p_mode64_only;
    (sf_rd_r || sf_wr_r) && !mode64_r |-> !(sf_comp_r == 3'h7)
      && !(sf_comp_r == 3'h1 && sf_idx_r >= 8'h24)
      && !(sf_comp_r == 3'h2 && sf_idx_r >= 8'h10)
      && !(sf_comp_r == 3'h6 && sf_idx_r >= 8'h20);
  endproperty
  a_mode64_only: assert property (p_mode64_only) else $error("64-bit section touched");

  property p_gated;
    (sf_rd_r || sf_wr_r) |-> lay.comp_en[sf_comp_r] && rfbm_r[sf_comp_r];
  endproperty
  a_gated: assert property (p_gated) else $error("disabled component touched");

  property p_ext_base;
    (sf_rd_r && sf_comp_r == 3'h2 && sf_idx_r == 8'h00 && !compact_r)
      |-> ##2 (mem_addr_r == base_r + 32'h00000240);
  endproperty
  a_ext_base: assert property (p_ext_base) else $error("extended region misplaced");

  property p_query;
    (reg_rd && reg_addr == ssave_pkg::REG_QUERY_OFF && qsel_r == 16'h020D)
      |=> reg_rdata == 32'h00000240;
  endproperty
  a_query: assert property (p_query) else $error("query offset wrong");

  property p_allow256;
    $rose(allow_vec256) |-> $past(feature_r[2]) && $past(ctrl_r[0]);
  endproperty
  a_allow256: assert property (p_allow256) else $error("256-bit ops allowed early");

  c_save_done:    cover property (op_done && !restore_r);
  c_restore_done: cover property (op_done && restore_r);
  c_fault:        cover property (gp_fault);
endmodule : state_save_unit
`default_nettype wire

// ==== verif/save_mem_model.sv ====
// partner: save area memory and state file, both answering in the cycle after a read strobe
`timescale 1ns/100ps
`default_nettype none
module save_mem_model (
  input  wire logic        mclk,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [31:0] mem_addr,
  input  wire logic [63:0] mem_wdata,
  input  wire logic [7:0]  mem_be,
  output var  logic [63:0] mem_rdata,
  input  wire logic        sf_rd,
  input  wire logic [2:0]  sf_comp,
  input  wire logic [7:0]  sf_idx,
  output var  logic [63:0] sf_rdata
);
  logic [63:0] mem [1024];
  // every word starts as its own index
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 64'(i);
    mem_rdata = '0;
    sf_rdata = '0;
  end
  // data in the cycle after the strobe, a toggling pattern otherwise
  always @(posedge mclk) begin
    mem_rdata <= mem_rd ? mem[mem_addr[12:3]] : ~mem_rdata;
    sf_rdata <= sf_rd ? {45'h0, sf_comp, sf_idx, 8'hC3} : ~sf_rdata;
    for (int b = 0; b < 8; b++)
      if (mem_wr && mem_be[b]) mem[mem_addr[12:3]][8*b +: 8] <= mem_wdata[8*b +: 8];
  end
endmodule : save_mem_model
`default_nettype wire

// ==== verif/state_save_unit_test.sv ====
// testbench: register access, gating, layout, save and restore sequences
`timescale 1ns/100ps
`default_nettype none
module state_save_unit_test;
  logic        mclk, reset_n, reg_wr, reg_rd, mem_rd, mem_wr, sf_rd, sf_wr;
  logic        gp_fault, op_done, allow_vec256, allow_bounds, allow_vec512, don, flt;
  logic [7:0]  reg_addr, mem_be, sf_idx;
  logic [31:0] reg_wdata, reg_rdata, mem_addr, d;
  logic [63:0] mem_wdata, mem_rdata, sf_wdata, sf_rdata, csr_w;
  logic [2:0]  sf_comp;
  int          mismatches, n_compared, n_wr, n_sfw, cyc, off;
  int          sz [8] = '{0, 0, 256, 64, 16, 64, 512, 1024};
  logic [7:0]  fv [4] = '{8'h07, 8'h1B, 8'hE3, 8'hFF};
  logic [2:0]  al [4] = '{3'b100, 3'b010, 3'b001, 3'b111};

  state_save_unit i_dut (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_be, .mem_rdata, .sf_rd, .sf_wr, .sf_comp,
    .sf_idx, .sf_wdata, .sf_rdata, .gp_fault, .op_done, .allow_vec256, .allow_bounds,
    .allow_vec512);
  save_mem_model i_mem (.mclk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_be, .mem_rdata,
    .sf_rd, .sf_comp, .sf_idx, .sf_rdata);

  function automatic int mi(input int o);
    mi = ((32'h1000 + o) >> 3) % 1024;
  endfunction : mi
  function automatic logic [63:0] pat(input logic [2:0] c, input logic [7:0] i);
    pat = {45'h0, c, i, 8'hC3};
  endfunction : pat
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string w);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, w, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // start a command and wait for its done or fault pulse
  task automatic run(input logic [31:0] cmd);
    n_wr = 0;
    n_sfw = 0;
    wr(ssave_pkg::REG_COMMAND, cmd);
    repeat (3000) begin
      @(posedge mclk);
      #1 {don, flt} = {op_done, gp_fault};
      if (don === 1'b1 || flt === 1'b1) break;
    end
    if (don !== 1'b1 && flt !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: command never finished", $time);
    end
  endtask : run

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // traffic counters and the run ceiling
  always @(posedge mclk) begin
    cyc++;
    if (mem_wr === 1'b1) n_wr++;
    if (sf_wr === 1'b1) n_sfw++;
    if (sf_wr === 1'b1 && sf_comp === 3'h1 && sf_idx === 8'h03) csr_w = sf_wdata;
    if (mem_wr === 1'b1) check(mem_be, 8'hFF, "byte enables");
    if (cyc == 20000) begin
      mismatches++;
      $display("unexpected at %0t: run ceiling reached", $time);
      final_report();
    end
  end

  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    rd(ssave_pkg::REG_FEATURE, d);
    check(d, 64'h01, "feature reset");
    wr(ssave_pkg::REG_FEATURE, 32'h0);
    rd(ssave_pkg::REG_FEATURE, d);
    check(d, 64'h01, "feature bit0");
    wr(ssave_pkg::REG_CONTROL, 32'h0);
    wr(ssave_pkg::REG_COMMAND, 32'h0200);
    rd(ssave_pkg::REG_STATUS, d);
    check(d[2], 1'b1, "refused");
    wr(ssave_pkg::REG_CONTROL, 32'h1);
    foreach (fv[k]) begin
      wr(ssave_pkg::REG_FEATURE, {24'h0, fv[k]});
      repeat (2) @(posedge mclk);
      check({allow_vec256, allow_bounds, allow_vec512}, al[k], "allow");
    end
    off = 576;
    for (int s = 2; s < 8; s++) begin
      wr(ssave_pkg::REG_QUERY_SEL, {16'h0, 8'(s), 8'h0D});
      rd(ssave_pkg::REG_QUERY_OFF, d);
      check(d, off, "query offset");
      rd(ssave_pkg::REG_QUERY_SZ, d);
      check(d, sz[s], "query size");
      off += sz[s];
    end
    wr(ssave_pkg::REG_BASE, 32'h1000);
    wr(ssave_pkg::REG_FEATURE, 32'h03);
    run(32'h0200);
    check(n_wr, 17, "save words");
    check(i_mem.mem[mi(24)], {ssave_pkg::CSR_MASK_VAL, 32'h000103C3}, "csr save");
    check(i_mem.mem[mi(160)], pat(1, 20), "vec0");
    check(i_mem.mem[mi(288)], mi(288), "vec8 untouched");
    wr(ssave_pkg::REG_CONTROL, 32'h3);
    wr(ssave_pkg::REG_FEATURE, 32'h07);
    run(32'h0600);
    check(n_wr, 65, "save words 64");
    check(i_mem.mem[mi(288)], pat(1, 36), "vec8");
    check(i_mem.mem[mi(576)], pat(2, 0), "upper0");
    check(i_mem.mem[mi(704)], pat(2, 16), "upper8");
    wr(ssave_pkg::REG_CONTROL, 32'h1);
    i_mem.mem[mi(24)] = 64'h0000_0000_0001_0000;
    run(32'h0201);
    check({don, flt, n_sfw}, {2'b01, 32'h0}, "bad csr");
    i_mem.mem[mi(24)] = 64'hFFFF_FFFF_0000_1F80;
    run(32'h0201);
    check(csr_w, 64'h1F80, "csr load");
    check(n_sfw, 17, "restore words");
    wr(ssave_pkg::REG_FEATURE, 32'hFF);
    run(32'h2002);
    check(n_wr, 8, "compact words");
    check(i_mem.mem[mi(576)], pat(5, 0), "compact mask0");
    check(i_mem.mem[mi(632)], pat(5, 7), "compact mask7");
    check(i_mem.mem[mi(912)], mi(912), "standard mask untouched");
    wr(ssave_pkg::REG_CONTROL, 32'h3);
    run(32'hFE00);
    check(n_wr, 275, "full save words");
    check(i_mem.mem[mi(848)], pat(3, 2), "bounds1");
    check(i_mem.mem[mi(904)], pat(4, 1), "bounds status");
    check(i_mem.mem[mi(912)], pat(5, 0), "mask0");
    check(i_mem.mem[mi(1232)], pat(6, 32), "wide upper8");
    check(i_mem.mem[mi(2448)], pat(7, 120), "wide reg31");
    final_report();
  end
endmodule : state_save_unit_test
`default_nettype wire
